// ---- dcdc_regs.svh ----
// Constants of the data compare debug control block: register numbers,
// field positions, reset values and mode codes.
// Assumes the includer works on 32-bit special-register data.
`ifndef DCDC_REGS_SVH
`define DCDC_REGS_SVH

// ----------------------------------------
// Special register numbers
// ----------------------------------------
`define DCDC_SPR_CTRL 10'h3BD
`define DCDC_SPR_STATUS 10'h3F0
`define DCDC_SPR_ADDR_A 10'h3F6
`define DCDC_SPR_ADDR_B 10'h3F7
`define DCDC_SPR_VALUE_A 10'h3B6
`define DCDC_SPR_VALUE_B 10'h3B7

// ----------------------------------------
// Control fields (bit 31 of the register is the word's MSB)
// ----------------------------------------
`define DCDC_RD_A 31
`define DCDC_RD_B 30
`define DCDC_WR_A 29
`define DCDC_WR_B 28
`define DCDC_GRAN_A_HI 27
`define DCDC_GRAN_A_LO 26
`define DCDC_GRAN_B_HI 25
`define DCDC_GRAN_B_LO 24
`define DCDC_RANGE_EN 23
`define DCDC_RANGE_X 22
`define DCDC_MODE_A_HI 19
`define DCDC_MODE_A_LO 18
`define DCDC_MODE_B_HI 17
`define DCDC_MODE_B_LO 16
`define DCDC_BE_A_HI 15
`define DCDC_BE_A_LO 12
`define DCDC_BE_B_HI 11
`define DCDC_BE_B_LO 8
`define DCDC_CTRL_WMASK 32'hFFCFFF00
`define DCDC_CTRL_RESET 32'h00000000

// ----------------------------------------
// Status fields and reset
// ----------------------------------------
`define DCDC_ST_RD_A 24
`define DCDC_ST_WR_A 23
`define DCDC_ST_RD_B 22
`define DCDC_ST_WR_B 21
`define DCDC_STATUS_RESET 32'h00000000
`define DCDC_WORD_RESET 32'h00000000

// ----------------------------------------
// Granularity and value modes
// ----------------------------------------
`define DCDC_GRAN_BYTE 2'h0
`define DCDC_GRAN_HALF 2'h1
`define DCDC_GRAN_WORD 2'h2
`define DCDC_MASK_BYTE 32'hFFFFFFFF
`define DCDC_MASK_HALF 32'hFFFFFFFE
`define DCDC_MASK_WORD 32'hFFFFFFFC
`define DCDC_MASK_LINE 32'hFFFFFFE0
`define DCDC_MODE_ALL 2'h1
`define DCDC_MODE_ANYB 2'h2
`define DCDC_MODE_ANYH 2'h3

`endif

// ---- dcdc_pkg.sv ----
// Types shared by the data compare debug control block.
// Assumes the constants header is included where numbers are needed.
package dcdc_pkg;
  typedef logic [31:0] dcdc_word_type;
  typedef logic [3:0] dcdc_be_type;
  typedef logic [1:0] dcdc_code_type;
endpackage

// ---- dcdc_top.sv ----
// Data compare debug control: control, comparator and status special
// registers, plus address and value compare logic on load/store traffic.
// Assumes one clock, core-synchronous inputs and one access per cycle.
`timescale 1ns/1ps
`include "dcdc_regs.svh"

module dcdc_top
  import dcdc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Special register access port
  input wire logic spr_rd_in,
  input wire logic spr_wr_in,
  input wire logic [9:0] spr_num_in,
  input wire logic spr_priv_in,
  input wire dcdc_word_type spr_wdata_in,
  output dcdc_word_type spr_rdata_out,
  output logic spr_ack_out,
  output logic spr_priv_fault_out,
  // Load/store pipeline
  input wire logic ls_valid_in,
  input wire logic ls_store_in,
  input wire dcdc_word_type ls_addr_in,
  input wire dcdc_word_type ls_data_in,
  // Debug events
  output logic addr_a_read_evt_out,
  output logic addr_b_read_evt_out,
  output logic addr_a_write_evt_out,
  output logic addr_b_write_evt_out,
  output logic value_a_evt_out,
  output logic value_b_evt_out
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  dcdc_word_type ctrl_r, ctrl_nxt;
  dcdc_word_type addr_a_r, addr_a_nxt;
  dcdc_word_type addr_b_r, addr_b_nxt;
  dcdc_word_type value_a_r, value_a_nxt;
  dcdc_word_type value_b_r, value_b_nxt;
  dcdc_word_type status_r, status_nxt;
  dcdc_word_type rdata_r, rdata_nxt;
  logic ack_r, ack_nxt;
  logic fault_r, fault_nxt;
  logic [5:0] evt_r, evt_nxt;

  logic addr_cmp_a_read_enable;
  logic addr_cmp_b_read_enable;
  logic addr_cmp_a_write_enable;
  logic addr_cmp_b_write_enable;
  dcdc_code_type addr_cmp_a_granularity;
  dcdc_code_type addr_cmp_b_granularity;
  logic addr_range_enable;
  logic addr_range_exclusive;
  dcdc_code_type value_cmp_a_mode;
  dcdc_code_type value_cmp_b_mode;
  dcdc_be_type value_cmp_a_byte_select;
  dcdc_be_type value_cmp_b_byte_select;

  assign addr_cmp_a_read_enable = ctrl_r[`DCDC_RD_A];
  assign addr_cmp_b_read_enable = ctrl_r[`DCDC_RD_B];
  assign addr_cmp_a_write_enable = ctrl_r[`DCDC_WR_A];
  assign addr_cmp_b_write_enable = ctrl_r[`DCDC_WR_B];
  assign addr_cmp_a_granularity = ctrl_r[`DCDC_GRAN_A_HI:`DCDC_GRAN_A_LO];
  assign addr_cmp_b_granularity = ctrl_r[`DCDC_GRAN_B_HI:`DCDC_GRAN_B_LO];
  assign addr_range_enable = ctrl_r[`DCDC_RANGE_EN];
  assign addr_range_exclusive = ctrl_r[`DCDC_RANGE_X];
  assign value_cmp_a_mode = ctrl_r[`DCDC_MODE_A_HI:`DCDC_MODE_A_LO];
  assign value_cmp_b_mode = ctrl_r[`DCDC_MODE_B_HI:`DCDC_MODE_B_LO];
  assign value_cmp_a_byte_select = ctrl_r[`DCDC_BE_A_HI:`DCDC_BE_A_LO];
  assign value_cmp_b_byte_select = ctrl_r[`DCDC_BE_B_HI:`DCDC_BE_B_LO];

  // ----------------------------------------
  // Address compare
  // ----------------------------------------
  function automatic dcdc_word_type gran_mask(input dcdc_code_type g);
    case (g)
      `DCDC_GRAN_BYTE: gran_mask = `DCDC_MASK_BYTE;
      `DCDC_GRAN_HALF: gran_mask = `DCDC_MASK_HALF;
      `DCDC_GRAN_WORD: gran_mask = `DCDC_MASK_WORD;
      default: gran_mask = `DCDC_MASK_LINE;
    endcase
  endfunction

  logic exact_a, exact_b, in_range, range_hit, hit_a, hit_b;

  // Comparator values are full byte addresses; no alignment is forced.
  assign exact_a = ((ls_addr_in ^ addr_a_r) & gran_mask(addr_cmp_a_granularity)) == 32'h00000000;
  assign exact_b = ((ls_addr_in ^ addr_b_r) & gran_mask(addr_cmp_b_granularity)) == 32'h00000000;
  assign in_range = (ls_addr_in >= addr_a_r) && (ls_addr_in < addr_b_r);
  assign range_hit = in_range ^ addr_range_exclusive;
  assign hit_a = addr_range_enable ? range_hit : exact_a;
  assign hit_b = addr_range_enable ? range_hit : exact_b;

  // ----------------------------------------
  // Value compare
  // ----------------------------------------
  logic [3:0] eq_a, eq_b;

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_byte
      assign eq_a[i] = ls_data_in[8*i+7:8*i] == value_a_r[8*i+7:8*i];
      assign eq_b[i] = ls_data_in[8*i+7:8*i] == value_b_r[8*i+7:8*i];
    end
  endgenerate

  function automatic logic value_hit(input dcdc_code_type m, input dcdc_be_type be,
                                     input logic [3:0] eq);
    logic [3:0] ok;
    logic hw_hi;
    logic hw_lo;
    ok = eq | ~be;
    hw_hi = (be[3] | be[2]) & ok[3] & ok[2];
    hw_lo = (be[1] | be[0]) & ok[1] & ok[0];
    case (m)
      `DCDC_MODE_ALL: value_hit = &ok;
      `DCDC_MODE_ANYB: value_hit = |(eq & be);
      `DCDC_MODE_ANYH: value_hit = hw_hi | hw_lo;
      default: value_hit = 1'b0;
    endcase
    // A zero byte select never fires, whatever the mode.
    value_hit = value_hit & (|be);
  endfunction

  logic val_a, val_b;

  assign val_a = value_hit(value_cmp_a_mode, value_cmp_a_byte_select, eq_a);
  assign val_b = value_hit(value_cmp_b_mode, value_cmp_b_byte_select, eq_b);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic acc_ok;
  logic ld, st;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    addr_a_nxt = addr_a_r;
    addr_b_nxt = addr_b_r;
    value_a_nxt = value_a_r;
    value_b_nxt = value_b_r;
    status_nxt = status_r;
    rdata_nxt = `DCDC_WORD_RESET;
    ack_nxt = 1'b0;
    fault_nxt = 1'b0;
    acc_ok = spr_priv_in;
    ld = ls_valid_in & ~ls_store_in;
    st = ls_valid_in & ls_store_in;

    evt_nxt[0] = ld & addr_cmp_a_read_enable & hit_a;
    evt_nxt[1] = ld & addr_cmp_b_read_enable & hit_b;
    evt_nxt[2] = st & addr_cmp_a_write_enable & hit_a;
    evt_nxt[3] = st & addr_cmp_b_write_enable & hit_b;
    evt_nxt[4] = ls_valid_in & val_a;
    evt_nxt[5] = ls_valid_in & val_b;

    if (spr_rd_in | spr_wr_in)
    begin
      ack_nxt = 1'b1;
      fault_nxt = ~acc_ok;
    end

    if (spr_wr_in && acc_ok)
    begin
      case (spr_num_in)
        `DCDC_SPR_CTRL: ctrl_nxt = spr_wdata_in & `DCDC_CTRL_WMASK;
        `DCDC_SPR_ADDR_A: addr_a_nxt = spr_wdata_in;
        `DCDC_SPR_ADDR_B: addr_b_nxt = spr_wdata_in;
        `DCDC_SPR_VALUE_A: value_a_nxt = spr_wdata_in;
        `DCDC_SPR_VALUE_B: value_b_nxt = spr_wdata_in;
        `DCDC_SPR_STATUS: status_nxt = status_r & ~spr_wdata_in;
        default: ;
      endcase
    end

    if (spr_rd_in && acc_ok)
    begin
      case (spr_num_in)
        `DCDC_SPR_CTRL: rdata_nxt = ctrl_r;
        `DCDC_SPR_ADDR_A: rdata_nxt = addr_a_r;
        `DCDC_SPR_ADDR_B: rdata_nxt = addr_b_r;
        `DCDC_SPR_VALUE_A: rdata_nxt = value_a_r;
        `DCDC_SPR_VALUE_B: rdata_nxt = value_b_r;
        `DCDC_SPR_STATUS: rdata_nxt = status_r;
        default: rdata_nxt = `DCDC_WORD_RESET;
      endcase
    end

    // Events are applied after the clear so a same-cycle event survives.
    if (evt_nxt[0])
      status_nxt[`DCDC_ST_RD_A] = 1'b1;
    if (evt_nxt[2])
      status_nxt[`DCDC_ST_WR_A] = 1'b1;
    if (evt_nxt[1])
      status_nxt[`DCDC_ST_RD_B] = 1'b1;
    if (evt_nxt[3])
      status_nxt[`DCDC_ST_WR_B] = 1'b1;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      ctrl_r <= `DCDC_CTRL_RESET;
      addr_a_r <= `DCDC_WORD_RESET;
      addr_b_r <= `DCDC_WORD_RESET;
      value_a_r <= `DCDC_WORD_RESET;
      value_b_r <= `DCDC_WORD_RESET;
      status_r <= `DCDC_STATUS_RESET;
      rdata_r <= `DCDC_WORD_RESET;
      ack_r <= 1'b0;
      fault_r <= 1'b0;
      evt_r <= 6'h00;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      addr_a_r <= addr_a_nxt;
      addr_b_r <= addr_b_nxt;
      value_a_r <= value_a_nxt;
      value_b_r <= value_b_nxt;
      status_r <= status_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      fault_r <= fault_nxt;
      evt_r <= evt_nxt;
    end
  end

  assign spr_rdata_out = rdata_r;
  assign spr_ack_out = ack_r;
  assign spr_priv_fault_out = fault_r;
  assign addr_a_read_evt_out = evt_r[0];
  assign addr_b_read_evt_out = evt_r[1];
  assign addr_a_write_evt_out = evt_r[2];
  assign addr_b_write_evt_out = evt_r[3];
  assign value_a_evt_out = evt_r[4];
  assign value_b_evt_out = evt_r[5];

endmodule

// ---- dcdc_props.sv ----
// Port-level checker for the data compare debug control block.
// Assumes it is bound to dcdc_top and sees only that module's ports.
`timescale 1ns/1ps

module dcdc_props
  import dcdc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Special register port
  input wire logic spr_rd_in,
  input wire logic spr_wr_in,
  input wire logic spr_priv_in,
  input wire dcdc_word_type spr_rdata_out,
  input wire logic spr_ack_out,
  input wire logic spr_priv_fault_out,
  // Load/store traffic and events
  input wire logic ls_valid_in,
  input wire logic ls_store_in,
  input wire logic addr_a_read_evt_out,
  input wire logic addr_b_read_evt_out,
  input wire logic addr_a_write_evt_out,
  input wire logic addr_b_write_evt_out,
  input wire logic value_a_evt_out,
  input wire logic value_b_evt_out
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  AST_ACK: assert property ((spr_rd_in || spr_wr_in) |=> spr_ack_out)
    else $error("access not acknowledged");
  AST_NO_ACK: assert property (!(spr_rd_in || spr_wr_in) |=> !spr_ack_out)
    else $error("acknowledge without access");
  AST_FAULT: assert property ((spr_rd_in || spr_wr_in) |=> spr_priv_fault_out != $past(spr_priv_in))
    else $error("privilege fault wrong");
  AST_PRIV_RD: assert property ((spr_rd_in && !spr_priv_in) |=> spr_rdata_out == 32'h00000000)
    else $error("unprivileged read returned data");
  AST_RDATA_IDLE: assert property (!spr_ack_out |-> spr_rdata_out == 32'h00000000)
    else $error("read data without acknowledge");
  AST_IDLE_EVT: assert property (!ls_valid_in |=> !(addr_a_read_evt_out || addr_b_read_evt_out ||
    addr_a_write_evt_out || addr_b_write_evt_out || value_a_evt_out || value_b_evt_out))
    else $error("event without access");
  AST_LOAD_NO_WR: assert property ((ls_valid_in && !ls_store_in) |=>
    !(addr_a_write_evt_out || addr_b_write_evt_out))
    else $error("write event on a load");
  AST_STORE_NO_RD: assert property ((ls_valid_in && ls_store_in) |=>
    !(addr_a_read_evt_out || addr_b_read_evt_out))
    else $error("read event on a store");
endmodule

bind dcdc_top dcdc_props u_props (.sys_clk_in, .resetn_in, .spr_rd_in, .spr_wr_in, .spr_priv_in,
  .spr_rdata_out, .spr_ack_out, .spr_priv_fault_out, .ls_valid_in, .ls_store_in, .addr_a_read_evt_out,
  .addr_b_read_evt_out, .addr_a_write_evt_out, .addr_b_write_evt_out, .value_a_evt_out, .value_b_evt_out);

// ---- dcdc_lsu_model.sv ----
// Load/store pipeline model: one access per call of access.
// Assumes its clock is the block's core clock.
`timescale 1ns/1ps

module dcdc_lsu_model
  import dcdc_pkg::*;
(
  // Clock
  input wire logic sys_clk_in,
  // Access to the block
  output logic ls_valid_out = 1'h0,
  output logic ls_store_out = 1'h0,
  output dcdc_word_type ls_addr_out = 32'h00000000,
  output dcdc_word_type ls_data_out = 32'h00000000
);
  // Address and data are inverted when idle so stale values never match.
  task automatic access(input logic st, input dcdc_word_type a, input dcdc_word_type d);
    @(posedge sys_clk_in);
    ls_valid_out <= 1'h1;
    ls_store_out <= st;
    ls_addr_out <= a;
    ls_data_out <= d;
    @(posedge sys_clk_in);
    ls_valid_out <= 1'h0;
    ls_addr_out <= ~a;
    ls_data_out <= ~d;
  endtask
endmodule

// ---- tb.sv ----
// Testbench for the data compare debug control block.
// Assumes the package, header, model and checker are compiled first.
`timescale 1ns/1ps
`include "dcdc_regs.svh"

module tb
  import dcdc_pkg::*;
;
  logic sys_clk_in = 1'h0;
  logic resetn_in = 1'h0;
  logic spr_rd_in = 1'h0, spr_wr_in = 1'h0, spr_priv_in = 1'h0;
  logic [9:0] spr_num_in = 10'h000;
  dcdc_word_type spr_wdata_in = 32'h00000000, spr_rdata_out, ls_addr_in, ls_data_in;
  logic spr_ack_out, spr_priv_fault_out, ls_valid_in, ls_store_in;
  logic addr_a_read_evt_out, addr_b_read_evt_out, addr_a_write_evt_out, addr_b_write_evt_out;
  logic value_a_evt_out, value_b_evt_out;
  int bad_count = 0, n_compared = 0;
  int nb[4] = '{0, 1, 2, 5};
  dcdc_word_type offs[4] = '{32'h1, 32'h3, 32'h1F, 32'h20};
  dcdc_word_type ads[4] = '{32'h0FFF, 32'h1000, 32'h1FFF, 32'h2000};
  dcdc_word_type dats[4] = '{32'h11223344, 32'h112233FF, 32'hFFFFFF44, 32'hAABBFF44};
  dcdc_be_type bes[4] = '{4'h0, 4'hF, 4'h3, 4'h9};
  logic [3:0] ens[3] = '{4'hF, 4'h6, 4'h9};

  always #5 sys_clk_in = ~sys_clk_in;

  dcdc_top dut (.sys_clk_in, .resetn_in, .spr_rd_in, .spr_wr_in, .spr_num_in, .spr_priv_in, .spr_wdata_in,
    .spr_rdata_out, .spr_ack_out, .spr_priv_fault_out, .ls_valid_in, .ls_store_in, .ls_addr_in, .ls_data_in,
    .addr_a_read_evt_out, .addr_b_read_evt_out, .addr_a_write_evt_out, .addr_b_write_evt_out,
    .value_a_evt_out, .value_b_evt_out);
  dcdc_lsu_model lsu (.sys_clk_in, .ls_valid_out(ls_valid_in), .ls_store_out(ls_store_in),
    .ls_addr_out(ls_addr_in), .ls_data_out(ls_data_in));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input dcdc_word_type got, input dcdc_word_type exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic spr(input logic wr, input logic priv, input logic [9:0] num, input dcdc_word_type d);
    @(posedge sys_clk_in);
    spr_rd_in <= !wr;
    spr_wr_in <= wr;
    spr_priv_in <= priv;
    spr_num_in <= num;
    spr_wdata_in <= d;
    @(posedge sys_clk_in);
    spr_rd_in <= 1'h0;
    spr_wr_in <= 1'h0;
    #1;
    check({30'h0, spr_ack_out, spr_priv_fault_out}, {30'h0, 1'h1, !priv});
  endtask

  task automatic ld(input logic st, input dcdc_word_type a, input dcdc_word_type d, input logic [5:0] e);
    lsu.access(st, a, d);
    #1;
    check({26'h0, addr_a_read_evt_out, addr_b_read_evt_out, addr_a_write_evt_out, addr_b_write_evt_out,
      value_a_evt_out, value_b_evt_out}, {26'h0, e});
  endtask

  // Expected value event: m mode, be byte selects, d data, v compare value.
  function automatic logic vm(input logic [1:0] m, input dcdc_be_type be, input dcdc_word_type d, v);
    dcdc_be_type ok;
    for (int i = 0; i < 4; i++)
      ok[i] = !be[i] || d[8*i +: 8] == v[8*i +: 8];
    case (m)
      2'h1: return |be && &ok;
      2'h2: return |(be & ok);
      2'h3: return (|be[3:2] && &ok[3:2]) || (|be[1:0] && &ok[1:0]);
      default: return 1'h0;
    endcase
  endfunction

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  // The whole sequence takes well under 2000 cycles; the watchdog allows 10000.
  initial
  begin
    #100000;
    bad_count++;
    close_out;
  end

  initial
  begin
    repeat (10) @(posedge sys_clk_in);
    resetn_in <= 1'h1;
    repeat (3) @(posedge sys_clk_in);
    spr(0, 1, `DCDC_SPR_CTRL, 32'h0);
    check(spr_rdata_out, 32'h00000000);
    spr(1, 1, `DCDC_SPR_CTRL, 32'hFFFFFFFF);
    spr(1, 0, `DCDC_SPR_CTRL, 32'h0);
    spr(0, 0, `DCDC_SPR_CTRL, 32'h0);
    check(spr_rdata_out, 32'h00000000);
    spr(0, 1, `DCDC_SPR_CTRL, 32'h0);
    check(spr_rdata_out, 32'hFFCFFF00);
    spr(0, 1, 10'h000, 32'h0);
    check(spr_rdata_out, 32'h00000000);
    spr(1, 1, `DCDC_SPR_ADDR_A, 32'h1000);
    spr(1, 1, `DCDC_SPR_ADDR_B, 32'h2000);
    spr(1, 1, `DCDC_SPR_VALUE_A, 32'h11223344);
    spr(1, 1, `DCDC_SPR_VALUE_B, 32'hAABB3344);
    spr(0, 1, `DCDC_SPR_ADDR_B, 32'h0);
    check(spr_rdata_out, 32'h2000);
    spr(0, 1, `DCDC_SPR_ADDR_A, 32'h0);
    check(spr_rdata_out, 32'h1000);
    spr(0, 1, `DCDC_SPR_VALUE_A, 32'h0);
    check(spr_rdata_out, 32'h11223344);
    spr(0, 1, `DCDC_SPR_VALUE_B, 32'h0);
    check(spr_rdata_out, 32'hAABB3344);
    foreach (ens[k])
    begin
      spr(1, 1, `DCDC_SPR_CTRL, {ens[k], 28'h0});
      for (int i = 0; i < 4; i++)
        ld(i[1], i[0] ? 32'h2000 : 32'h1000, 32'h0, {ens[k] & {!i[1] && !i[0], !i[1] && i[0],
          i[1] && !i[0], i[1] && i[0]}, 2'h0});
    end
    for (int g = 0; g < 4; g++)
    begin
      spr(1, 1, `DCDC_SPR_CTRL, {4'hC, g[1:0], 2'(3 - g), 24'h0});
      foreach (offs[j])
      begin
        ld(0, 32'h1000 | offs[j], 32'h0, {(offs[j] >> nb[g]) == 0, 5'h00});
        ld(0, 32'h2000 | offs[j], 32'h0, {1'h0, (offs[j] >> nb[3 - g]) == 0, 4'h0});
      end
    end
    for (int x = 0; x < 2; x++)
    begin
      spr(1, 1, `DCDC_SPR_CTRL, {8'h90, 1'h1, x[0], 22'h0});
      foreach (ads[j])
      begin
        ld(0, ads[j], 32'h0, {(j == 1 || j == 2) ^ x[0], 5'h00});
        ld(1, ads[j], 32'h0, {3'h0, (j == 1 || j == 2) ^ x[0], 2'h0});
      end
    end
    for (int m = 0; m < 4; m++)
      foreach (bes[j])
      begin
        spr(1, 1, `DCDC_SPR_CTRL, {12'h0, m[1:0], 2'(m + 1), bes[j], bes[(j + 1) % 4], 8'h00});
        foreach (dats[k])
          ld(k[0], 32'h3000, dats[k], {4'h0, vm(m[1:0], bes[j], dats[k], 32'h11223344),
            vm(2'(m + 1), bes[(j + 1) % 4], dats[k], 32'hAABB3344)});
      end
    spr(1, 1, `DCDC_SPR_STATUS, 32'hFFFFFFFF);
    spr(1, 1, `DCDC_SPR_CTRL, 32'h80000000);
    ld(0, 32'h1000, 32'h0, 6'h20);
    spr(0, 1, `DCDC_SPR_STATUS, 32'h0);
    check(spr_rdata_out, 32'h01000000);
    // A clear and a matching load in one cycle must leave the status bit set.
    fork
      spr(1, 1, `DCDC_SPR_STATUS, 32'hFFFFFFFF);
      lsu.access(0, 32'h1000, 32'h0);
    join
    spr(0, 1, `DCDC_SPR_STATUS, 32'h0);
    check(spr_rdata_out, 32'h01000000);
    spr(1, 1, `DCDC_SPR_STATUS, 32'h01000000);
    spr(0, 1, `DCDC_SPR_STATUS, 32'h0);
    check(spr_rdata_out, 32'h00000000);
    close_out;
  end
endmodule
